/* rtl/stka_pkg.sv */
// Constants and types for the serial timekeeper access block
package stka_pkg;

  // Unlock key, byte 0 in the low bits; each byte goes out LSB first
  localparam logic [63:0] KEY_PATTERN = 64'h5ca33ac5_5ca33ac5;
  localparam int          KEY_BITS    = 64;
  localparam logic [5:0]  LAST_BIT    = 6'h3f;

  // Timekeeping register indices
  localparam int HUNDREDTHS_IDX            = 0;
  localparam int SECONDS_IDX               = 1;
  localparam int MINUTES_IDX               = 2;
  localparam int HOUR_COUNT_AND_FORMAT_IDX = 3;
  localparam int WEEKDAY_AND_CONTROL_IDX   = 4;
  localparam int DATE_IDX                  = 5;
  localparam int MONTH_IDX                 = 6;
  localparam int YEAR_IDX                  = 7;

  // Field positions
  localparam int HOUR_FMT_BIT   = 7;
  localparam int AFTERNOON_BIT  = 5;
  localparam int ABORT_GATE_BIT = 4;
  localparam int OSC_STOP_BIT   = 5;

  // Implemented bits per register; the rest always read zero
  localparam logic [7:0][7:0] BIT_MASK = {8'hff, 8'h1f, 8'h3f, 8'h37,
                                          8'hbf, 8'h7f, 8'h7f, 8'hff};

  // Reset contents: abort gate and oscillator stop set, date 01/01
  localparam logic [7:0][7:0] RESET_TK = {8'h00, 8'h01, 8'h01, 8'h30,
                                          8'h00, 8'h00, 8'h00, 8'h00};

  // Timekeeping tick: one hundredth of a second
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 10_000_000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W    = 21;

  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_HUNT,
    ST_XFER
  } stka_state_t;

  typedef struct packed {
    stka_state_t            st;
    logic [5:0]             ptr;
    logic [7:0][7:0]        tk;
    logic [63:0]            shadow;
    logic                   wrote;
    logic [TICK_CNT_W-1:0]  div;
    logic                   wr_q;
    logic                   rd_q;
    logic                   din_q;
    logic                   dout;
  } stka_regs_t;

endpackage : stka_pkg

/* rtl/stka_serial_timekeeper.sv */
// Hidden serial timekeeper behind an asynchronous SRAM socket
// Contract
// - Key is C5 3A A3 5C C5 3A A3 5C, one bit per write.
// - Each key byte goes least significant bit first.
// - Hours bit 7 high selects 12-hour, low selects 24-hour.
// - In 12-hour format hours bit 5 high means PM.
// - In 24-hour format hours bit 5 is upper tens bit, hours 20-23.
// - Day bit 4 low lets low abort input end transfer, data unchanged.
// - Day bit 5 high stops the oscillator, low runs timekeeping.
// - Abort gate and oscillator stop bits both start at 1.
// - Unused bits of registers 1 to 6 always read 0.
// - Writes to unused bits accept 0 or 1 and still read 0.
// - Write window is overlap of chip select low and write strobe low.
// - Write data is taken at the end of the write window.
// - Output enable high during a write keeps the data lane undriven.
// - Write strobe low at or before chip select keeps lane undriven.
// - Undriven abort input counts as inactive high.
// - Any read during recognition rewinds the pointer to key bit 0.
// - Match advances pointer; mismatch freezes it, later writes ignored.
// - After 64 matches next 64 cycles move clock bits, memory blocked.
// - Transfers walk bit 0 of register 0 up to bit 7 of register 7.
`timescale 1ns/100ps

module stka_serial_timekeeper #(
  parameter int unsigned TICK_CYCLES = stka_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Socket strobes, all active low
  input  wire logic ce_n,
  input  wire logic oe_n,
  input  wire logic we_n,
  input  wire logic abort_n,
  // Serial data lane
  input  wire logic serial_bit_lane_i,
  output logic      serial_bit_lane_o,
  output logic      serial_bit_lane_oe,
  // Memory side
  output logic      mem_block,
  output logic      osc_running
);

  localparam logic [stka_pkg::TICK_CNT_W-1:0] TICK_LAST =
    stka_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  stka_pkg::stka_regs_t q;
  stka_pkg::stka_regs_t n;

  logic wr_now;
  logic rd_now;
  logic wr_end;
  logic rd_end;
  logic abort;
  logic tick;
  logic commit;
  logic key_hit;

  // BCD step with wrap: returns {carry, next}
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] r;
    if (v == last)
      r = {1'b1, first};
    else if (v[3:0] == 4'h9)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_step

  // Last date of a month, BCD
  function automatic logic [7:0] month_last(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic       leap;
    logic [7:0] r;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == 8'h02)
      r = leap ? 8'h29 : 8'h28;
    else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
      r = 8'h30;
    else
      r = 8'h31;
    return r;
  endfunction : month_last

  // One hundredth of a second forward through the whole calendar
  function automatic logic [7:0][7:0] advance(input logic [7:0][7:0] t);
    logic [7:0][7:0] r;
    logic [8:0]      s;
    logic [7:0]      h;
    logic            c;
    r = t;
    h = t[stka_pkg::HOUR_COUNT_AND_FORMAT_IDX];
    s = bcd_step(t[0], 8'h99, 8'h00);
    r[0] = s[7:0];
    c = s[8];
    if (c)
    begin
      s = bcd_step(t[1], 8'h59, 8'h00);
      r[1] = s[7:0];
      c = s[8];
    end
    if (c)
    begin
      s = bcd_step(t[2], 8'h59, 8'h00);
      r[2] = s[7:0];
      c = s[8];
    end
    if (c)
    begin
      if (h[stka_pkg::HOUR_FMT_BIT])
      begin
        // 11 -> 12 flips the afternoon flag; day rolls at midnight
        if (h[4:0] == 5'h11)
        begin
          r[3] = {h[7], 1'b0, ~h[5], 5'h12};
          c = h[5];
        end
        else if (h[4:0] == 5'h12)
        begin
          r[3] = {h[7], 1'b0, h[5], 5'h01};
          c = 1'b0;
        end
        else
        begin
          s = bcd_step({3'h0, h[4:0]}, 8'h12, 8'h01);
          r[3] = {h[7], 1'b0, h[5], s[4:0]};
          c = 1'b0;
        end
      end
      else
      begin
        s = bcd_step({2'h0, h[5:0]}, 8'h23, 8'h00);
        r[3] = {2'h0, s[5:0]};
        c = s[8];
      end
    end
    if (c)
    begin
      r[4][2:0] = (t[4][2:0] == 3'h7) ? 3'h1 : t[4][2:0] + 3'h1;
      s = bcd_step(t[5], month_last(t[6], t[7]), 8'h01);
      r[5] = s[7:0];
      c = s[8];
    end
    if (c)
    begin
      s = bcd_step(t[6], 8'h12, 8'h01);
      r[6] = s[7:0];
      c = s[8];
    end
    if (c)
    begin
      s = bcd_step(t[7], 8'h99, 8'h00);
      r[7] = s[7:0];
    end
    return r;
  endfunction : advance

  always_comb
  begin
    n = q;
    wr_now = !ce_n && !we_n;
    rd_now = !ce_n && !oe_n && we_n;
    wr_end = q.wr_q && !wr_now;
    rd_end = q.rd_q && !rd_now;
    // Only a driven low aborts; the pin idles high via its pull-up
    abort = !abort_n
            && !q.tk[stka_pkg::WEEKDAY_AND_CONTROL_IDX][stka_pkg::ABORT_GATE_BIT];
    key_hit = (q.din_q == stka_pkg::KEY_PATTERN[q.ptr]);
    commit = 1'b0;
    tick = (q.div == TICK_LAST);
    n.wr_q = wr_now;
    n.rd_q = rd_now;
    // Lane keeps following until the window closes
    if (wr_now)
      n.din_q = serial_bit_lane_i;
    n.div = tick ? '0 : q.div + 1'b1;
    if (tick && !q.tk[stka_pkg::WEEKDAY_AND_CONTROL_IDX][stka_pkg::OSC_STOP_BIT])
      n.tk = advance(q.tk);
    unique case (q.st)
      stka_pkg::ST_LOCKED:
      begin
        if (rd_end)
        begin
          n.st = stka_pkg::ST_HUNT;
          n.ptr = '0;
        end
      end
      stka_pkg::ST_HUNT:
      begin
        if (abort)
          n.st = stka_pkg::ST_LOCKED;
        else if (rd_end)
          n.ptr = '0;
        else if (wr_end && !key_hit)
          n.st = stka_pkg::ST_LOCKED;
        else if (wr_end && q.ptr == stka_pkg::LAST_BIT)
        begin
          // Snapshot so a read burst sees one coherent time
          n.st = stka_pkg::ST_XFER;
          n.ptr = '0;
          n.shadow = q.tk;
          n.wrote = 1'b0;
          n.dout = q.tk[0][0];
        end
        else if (wr_end)
          n.ptr = q.ptr + 6'h1;
      end
      stka_pkg::ST_XFER:
      begin
        if (abort)
          n.st = stka_pkg::ST_LOCKED;
        else if (wr_end || rd_end)
        begin
          if (wr_end)
          begin
            n.shadow[q.ptr] = q.din_q;
            n.wrote = 1'b1;
          end
          if (q.ptr == stka_pkg::LAST_BIT)
          begin
            n.st = stka_pkg::ST_LOCKED;
            commit = q.wrote || wr_end;
            // Whole-set commit avoids a torn update of a partial write
            if (commit)
              n.tk = n.shadow & stka_pkg::BIT_MASK;
          end
          else
          begin
            n.ptr = q.ptr + 6'h1;
            n.dout = q.shadow[q.ptr + 6'h1];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= stka_pkg::ST_LOCKED;
      q.tk <= stka_pkg::RESET_TK;
    end
    else
      q <= n;
  end

  assign serial_bit_lane_o = q.dout;
  // Strobe-qualified drive: any write strobe low keeps the lane off
  assign serial_bit_lane_oe = rd_now && (q.st == stka_pkg::ST_XFER);
  assign mem_block = (q.st == stka_pkg::ST_XFER);
  assign osc_running =
    !q.tk[stka_pkg::WEEKDAY_AND_CONTROL_IDX][stka_pkg::OSC_STOP_BIT];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  lane_quiet_write_a: assert property (!we_n || oe_n |-> !serial_bit_lane_oe)
    else $error("data lane driven during write or without output enable");

  mismatch_locks_a: assert property (
    q.st == stka_pkg::ST_HUNT && !abort && !rd_end && wr_end && !key_hit
    |=> q.st == stka_pkg::ST_LOCKED ##1 q.ptr == $past(q.ptr, 2))
    else $error("mismatch did not freeze recognition");

  read_rewinds_a: assert property (
    q.st == stka_pkg::ST_HUNT && !abort && rd_end
    |=> q.st == stka_pkg::ST_HUNT && q.ptr == 6'h0)
    else $error("read did not rewind key pointer");

  match_steps_a: assert property (
    q.st == stka_pkg::ST_HUNT && !abort && !rd_end && wr_end && key_hit
    && q.ptr != stka_pkg::LAST_BIT |=> q.ptr == $past(q.ptr) + 6'h1)
    else $error("matching key bit did not advance pointer");

  key_opens_a: assert property (
    q.st == stka_pkg::ST_HUNT && !abort && !rd_end && wr_end && key_hit
    && q.ptr == stka_pkg::LAST_BIT |=> mem_block && q.ptr == 6'h0)
    else $error("full key did not open transfer");

  xfer_closes_a: assert property (
    q.st == stka_pkg::ST_XFER && !abort && (wr_end || rd_end)
    && q.ptr == stka_pkg::LAST_BIT |=> !mem_block [*2])
    else $error("transfer did not end after 64th cycle");

  abort_ends_a: assert property (
    q.st == stka_pkg::ST_XFER && abort |=> !mem_block && !commit)
    else $error("abort did not end transfer");

  abort_gated_a: assert property (
    q.st == stka_pkg::ST_XFER && !abort && !wr_end && !rd_end |=> mem_block)
    else $error("transfer ended without cause");

  zero_bits_a: assert property ((q.tk & ~stka_pkg::BIT_MASK) == '0)
    else $error("unused timekeeping bit reads one");

  osc_stop_a: assert property (
    q.tk[stka_pkg::WEEKDAY_AND_CONTROL_IDX][stka_pkg::OSC_STOP_BIT] && !commit
    |=> $stable(q.tk[stka_pkg::HUNDREDTHS_IDX]))
    else $error("time advanced with oscillator stopped");

  hour12_range_a: assert property (
    q.tk[stka_pkg::HOUR_COUNT_AND_FORMAT_IDX][stka_pkg::HOUR_FMT_BIT] && tick && !commit
    && q.tk[3][4:0] == 5'h11 && q.tk[2] == 8'h59 && q.tk[1] == 8'h59
    && q.tk[0] == 8'h99 && osc_running
    |=> q.tk[3][stka_pkg::AFTERNOON_BIT] != $past(q.tk[3][stka_pkg::AFTERNOON_BIT]))
    else $error("afternoon flag did not flip at twelve");

  abort_keeps_time_a: assert property (
    q.st == stka_pkg::ST_XFER && abort
    |=> q.tk == ($past(tick && osc_running) ? advance($past(q.tk)) : $past(q.tk)))
    else $error("abort changed timekeeping registers");

  hour24_tens_a: assert property (
    !q.tk[stka_pkg::HOUR_COUNT_AND_FORMAT_IDX][stka_pkg::HOUR_FMT_BIT] && tick && !commit
    && q.tk[3] == 8'h19 && q.tk[2] == 8'h59 && q.tk[1] == 8'h59
    && q.tk[0] == 8'h99 && osc_running
    |=> q.tk[3] == 8'h20)
    else $error("24-hour count did not carry into upper tens bit");

  lock_ignores_a: assert property (
    q.st == stka_pkg::ST_LOCKED && !rd_end
    |=> q.st == stka_pkg::ST_LOCKED && q.ptr == $past(q.ptr))
    else $error("locked state reacted to a write");

  lane_tracks_a: assert property (
    q.st == stka_pkg::ST_XFER && rd_now |-> serial_bit_lane_o == q.shadow[q.ptr])
    else $error("data lane not showing current transfer bit");

  enter_xfer_c: cover property (q.st == stka_pkg::ST_HUNT ##1 q.st == stka_pkg::ST_XFER);
  noon_c:       cover property (q.tk[3] == 8'hb2 && q.tk[2] == 8'h00);
  commit_c:     cover property (commit);
  abort_c:      cover property (q.st == stka_pkg::ST_XFER && abort);
  lock_c:       cover property (q.st == stka_pkg::ST_HUNT && wr_end && !key_hit);

endmodule : stka_serial_timekeeper

/* verification/stka_host_model.sv */
// Host bus master model driving the socket strobes and the data lane
`timescale 1ns/100ps

module stka_host_model (
  // Clock
  input  wire logic core_clk,
  // Socket strobes
  output logic      ce_n,
  output logic      oe_n,
  output logic      we_n,
  output logic      abort_n,
  // Data lane
  output logic      lane,
  input  wire logic lane_o,
  input  wire logic lane_oe
);
  logic drv;
  logic [7:0] key_bytes [8] = '{8'hc5, 8'h3a, 8'ha3, 8'h5c, 8'hc5, 8'h3a, 8'ha3, 8'h5c};
  // Released lane shows the inverse of the last value, never a stale copy
  assign lane = lane_oe ? lane_o : drv;
  initial
  begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    abort_n = 1'b1;
    drv = 1'b0;
  end
  function automatic logic key_bit(input int k);
    return key_bytes[k / 8][k % 8];
  endfunction : key_bit
  task automatic wr(input logic b, output logic oe_seen);
    @(posedge core_clk);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    oe_n <= 1'b0;
    drv <= b;
    @(negedge core_clk);
    oe_seen = lane_oe;
    @(posedge core_clk);
    ce_n <= 1'b1;
    we_n <= 1'b1;
    oe_n <= 1'b1;
    drv <= ~b;
  endtask : wr
  task automatic rd(output logic b, output logic oe_seen);
    @(posedge core_clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    @(negedge core_clk);
    b = lane;
    oe_seen = lane_oe;
    @(posedge core_clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    drv <= ~drv;
  endtask : rd
  task automatic pulse_abort();
    @(posedge core_clk);
    abort_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    abort_n <= 1'b1;
  endtask : pulse_abort
endmodule : stka_host_model

/* verification/serial_timekeeper_access_tb_top.sv */
// Self-checking testbench for the serial timekeeper access block
`timescale 1ns/100ps

module serial_timekeeper_access_tb_top;
  logic core_clk, rst_n, ce_n, oe_n, we_n, abort_n;
  logic lane, lane_o, lane_oe, mem_block, osc_running, b, s;
  logic [7:0][7:0] r;
  int err_count, compares;

  stka_serial_timekeeper #(.TICK_CYCLES(4)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .abort_n(abort_n), .serial_bit_lane_i(lane), .serial_bit_lane_o(lane_o),
    .serial_bit_lane_oe(lane_oe), .mem_block(mem_block), .osc_running(osc_running));
  stka_host_model i_host (.core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .abort_n(abort_n), .lane(lane), .lane_o(lane_o), .lane_oe(lane_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // State changes one edge after a cycle ends; look away from the edges
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask : settle
  task automatic key_part(input int n, input int bad);
    i_host.rd(b, s);
    for (int k = 0; k < n; k++) i_host.wr(i_host.key_bit(k) ^ (k == bad), s);
    settle();
  endtask : key_part
  task automatic xfer_rd();
    for (int k = 0; k < 64; k++)
    begin
      i_host.rd(b, s);
      r[k / 8][k % 8] = b;
      chk({7'h00, s}, 8'h01, "lane enable on read");
    end
    settle();
  endtask : xfer_rd
  task automatic xfer_wr(input logic [7:0][7:0] w);
    for (int k = 0; k < 64; k++)
    begin
      i_host.wr(w[k / 8][k % 8], s);
      chk({7'h00, s}, 8'h00, "lane enable on write");
    end
    settle();
  endtask : xfer_wr
  task automatic t_reset_read();
    chk({7'h00, osc_running}, 8'h00, "osc at reset");
    key_part(64, -1);
    chk({7'h00, mem_block}, 8'h01, "unlocked");
    i_host.pulse_abort();
    chk({7'h00, mem_block}, 8'h01, "gated abort");
    xfer_rd();
    for (int i = 0; i < 8; i++) chk(r[i], stka_pkg::RESET_TK[i], "reset reg");
    chk({7'h00, mem_block}, 8'h00, "relocked");
    $display("test reset_read done");
  endtask : t_reset_read
  task automatic t_bad_key();
    key_part(64, 5);
    chk({7'h00, mem_block}, 8'h00, "bad key");
    key_part(20, -1);
    key_part(64, -1);
    chk({7'h00, mem_block}, 8'h01, "read rewinds");
    xfer_rd();
    $display("test bad_key done");
  endtask : t_bad_key
  task automatic t_zero_bits();
    key_part(64, -1);
    xfer_wr({8{8'hff}});
    key_part(64, -1);
    xfer_rd();
    for (int i = 0; i < 8; i++) chk(r[i], stka_pkg::BIT_MASK[i], "zero bits");
    chk({7'h00, r[3][7]}, 8'h01, "12h select");
    $display("test zero_bits done");
  endtask : t_zero_bits
  task automatic t_osc_abort();
    logic [7:0][7:0] w;
    w = stka_pkg::RESET_TK;
    w[4] = 8'h00;
    key_part(64, -1);
    xfer_wr(w);
    repeat (2) @(posedge core_clk);
    chk({7'h00, osc_running}, 8'h01, "osc runs");
    key_part(64, -1);
    for (int k = 0; k < 10; k++) i_host.rd(b, s);
    // Partial write must be dropped by the abort
    for (int k = 0; k < 10; k++) i_host.wr(1'b1, s);
    i_host.pulse_abort();
    chk({7'h00, mem_block}, 8'h00, "abort ends xfer");
    key_part(64, -1);
    xfer_rd();
    chk(r[1], 8'h00, "abort keeps seconds");
    chk(r[2], 8'h00, "abort keeps minutes");
    chk({7'h00, r[0] != 8'h00}, 8'h01, "time advances");
    $display("test osc_abort done");
  endtask : t_osc_abort
  task automatic t_hours();
    logic [7:0][7:0] w;
    // 11:59:59.99 before noon, 12-hour mode, abort ignored, oscillator on
    w = {8'h00, 8'h01, 8'h01, 8'h11, 8'h91, 8'h59, 8'h59, 8'h99};
    key_part(64, -1);
    xfer_wr(w);
    key_part(64, -1);
    xfer_rd();
    chk(r[3], 8'hb2, "noon sets afternoon flag");
    chk(r[5], 8'h01, "no date roll at noon");
    w[3] = 8'h19;
    key_part(64, -1);
    xfer_wr(w);
    key_part(64, -1);
    xfer_rd();
    chk(r[3], 8'h20, "24h upper tens bit");
    chk(r[2], 8'h00, "minutes roll over");
    $display("test hours done");
  endtask : t_hours

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    #500_000;
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim();
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_read();
    t_bad_key();
    t_zero_bits();
    t_osc_abort();
    t_hours();
    end_sim();
  end
endmodule : serial_timekeeper_access_tb_top
